/* File: src/anps_defines.vh */
// Offsets, field positions, reset values and counts of the partner status bank
`ifndef ANPS_DEFINES_VH
`define ANPS_DEFINES_VH

`define ANPS_ADDR_W          5
`define ANPS_DATA_W          16
`define ANPS_OFF_ADVERT      5'h04
`define ANPS_OFF_PARTNER     5'h05
`define ANPS_OFF_EXPAND      5'h06
`define ANPS_OFF_IRQ_STAT    5'h18
`define ANPS_OFF_IRQ_MASK    5'h19

`define ANPS_PA_NEXT_PAGE    15
`define ANPS_PA_ACK          14
`define ANPS_PA_RFAULT       13
`define ANPS_PA_PAUSE        10
`define ANPS_PA_T4           9
`define ANPS_PA_TX_FD        8
`define ANPS_PA_TX           7
`define ANPS_PA_10_FD        6
`define ANPS_PA_10           5
`define ANPS_PA_SEL_HI       4
`define ANPS_PA_SEL_LO       0

`define ANPS_EX_PDF          4
`define ANPS_EX_LP_NP        3
`define ANPS_EX_NP_ABLE      2
`define ANPS_EX_PAGE_RX      1
`define ANPS_EX_LP_AN        0

`define ANPS_SEL_8023        5'h01
`define ANPS_SEL_8029        5'h02
`define ANPS_SEL_RSV_LO      5'h00
`define ANPS_SEL_RSV_HI      5'h1F

`define ANPS_ADV_RESET       16'h0181
`define ANPS_EXPAND_RESET    16'h0000
`define ANPS_MATCH_COUNT     3

`define ANPS_IRQ_W           2
`define ANPS_IRQ_PDF         0
`define ANPS_IRQ_PAGE        1

`endif

/* File: src/anps_partner_status.v */
// Auto-negotiation partner ability and expansion status register bank
`timescale 1ns/1ps
`include "anps_defines.vh"

module anps_partner_status #(
   parameter MATCH_COUNT = `ANPS_MATCH_COUNT
) (
   input  wire                      SYS_CLK,
   input  wire                      RESET,
   input  wire [`ANPS_ADDR_W-1:0]   ADDR,
   input  wire [`ANPS_DATA_W-1:0]   WDATA,
   input  wire                      WR,
   input  wire                      RD,
   output reg  [`ANPS_DATA_W-1:0]   RDATA,
   input  wire                      CW_VALID,
   input  wire [`ANPS_DATA_W-1:0]   CW_DATA,
   input  wire                      LP_AN_ABLE,
   input  wire                      PD_FAULT,
   input  wire                      NEG_RESTART,
   input  wire                      SPEED_CONFIG_PIN,
   output wire [`ANPS_DATA_W-1:0]   ADVERT,
   output wire                      IRQ
);

   reg  [`ANPS_DATA_W-1:0] partner_q;
   reg  [`ANPS_DATA_W-1:0] last_cw_q;
   reg  [1:0]              match_cnt_q;
   reg  [1:0]              match_cnt_d;
   reg                     page_rx_q;
   reg                     pdf_q;
   reg                     lp_an_q;
   reg  [`ANPS_DATA_W-1:0] advert_q;
   reg                     strap_done_q;
   reg  [`ANPS_IRQ_W-1:0]  irq_stat_q;
   reg  [`ANPS_IRQ_W-1:0]  irq_mask_q;
   reg  [`ANPS_DATA_W-1:0] rdata_d;
   wire [`ANPS_DATA_W-1:0] expand_w;
   wire                    page_evt;
   wire                    rd_expand;
   wire [`ANPS_IRQ_W-1:0]  evt;

   function is_addr;
      input [`ANPS_ADDR_W-1:0] a;
      input [`ANPS_ADDR_W-1:0] off;
      begin
         is_addr = (a == off);
      end
   endfunction

   assign rd_expand = RD && is_addr(ADDR, `ANPS_OFF_EXPAND);

   // Count identical consecutive codewords; restart on any difference
   always @* begin
      match_cnt_d = match_cnt_q;
      if (CW_VALID) begin
         if (match_cnt_q != 2'd0 && CW_DATA == last_cw_q) begin
            if (match_cnt_q != MATCH_COUNT[1:0]) begin
               match_cnt_d = match_cnt_q + 2'd1;
            end
         end else begin
            match_cnt_d = 2'd1;
         end
      end
   end

   assign page_evt = CW_VALID && (match_cnt_d == MATCH_COUNT[1:0])
                     && (match_cnt_q != MATCH_COUNT[1:0]);

   always @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         last_cw_q   <= 16'h0000;
         match_cnt_q <= 2'd0;
         partner_q   <= 16'h0000;
      end else if (NEG_RESTART) begin
         match_cnt_q <= 2'd0;
         partner_q   <= 16'h0000;
      end else begin
         if (CW_VALID) begin
            last_cw_q <= CW_DATA;
         end
         match_cnt_q <= match_cnt_d;
         // captured codeword bits incl. next page
         if (page_evt) begin
            partner_q <= CW_DATA & 16'hE7FF;
         end
      end
   end

   // sticky bits, set wins over read-clear
   always @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         page_rx_q <= 1'b0;
         pdf_q     <= 1'b0;
         lp_an_q   <= 1'b0;
      end else begin
         if (page_evt) begin
            page_rx_q <= 1'b1;
         end else if (rd_expand) begin
            page_rx_q <= 1'b0;
         end
         if (PD_FAULT) begin
            pdf_q <= 1'b1;
         end else if (rd_expand) begin
            pdf_q <= 1'b0;
         end
         if (NEG_RESTART) begin
            lp_an_q <= 1'b0;
         end else if (LP_AN_ABLE) begin
            lp_an_q <= 1'b1;
         end
      end
   end

   assign expand_w = {11'h000, pdf_q, partner_q[`ANPS_PA_NEXT_PAGE],
                      1'b0, page_rx_q, lp_an_q};

   // pin strap sampled after reset release
   always @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         advert_q     <= `ANPS_ADV_RESET;
         strap_done_q <= 1'b0;
      end else begin
         if (!strap_done_q) begin
            advert_q[`ANPS_PA_10] <= SPEED_CONFIG_PIN;
            strap_done_q          <= 1'b1;
         end else if (WR && is_addr(ADDR, `ANPS_OFF_ADVERT)) begin
            // Next page and bit 14 stay zero
            advert_q <= WDATA & 16'h3FFF;
         end
      end
   end

   assign ADVERT = advert_q;

   assign evt = {page_evt, PD_FAULT};

   // Status write-one-to-clear; a coincident event keeps the bit
   always @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         irq_stat_q <= 2'b00;
         irq_mask_q <= 2'b00;
      end else begin
         if (WR && is_addr(ADDR, `ANPS_OFF_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~WDATA[`ANPS_IRQ_W-1:0]) | evt;
         end else begin
            irq_stat_q <= irq_stat_q | evt;
         end
         if (WR && is_addr(ADDR, `ANPS_OFF_IRQ_MASK)) begin
            irq_mask_q <= WDATA[`ANPS_IRQ_W-1:0];
         end
      end
   end

   assign IRQ = |(irq_stat_q & irq_mask_q);

   // writes to partner and expansion ignored
   always @* begin
      rdata_d = 16'h0000;
      if (is_addr(ADDR, `ANPS_OFF_ADVERT)) begin
         rdata_d = advert_q;
      end else if (is_addr(ADDR, `ANPS_OFF_PARTNER)) begin
         rdata_d = partner_q;
      end else if (is_addr(ADDR, `ANPS_OFF_EXPAND)) begin
         rdata_d = expand_w;
      end else if (is_addr(ADDR, `ANPS_OFF_IRQ_STAT)) begin
         rdata_d = {14'h0000, irq_stat_q};
      end else if (is_addr(ADDR, `ANPS_OFF_IRQ_MASK)) begin
         rdata_d = {14'h0000, irq_mask_q};
      end
   end

   // Read data valid one cycle after strobe only
   always @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         RDATA <= 16'h0000;
      end else if (RD) begin
         RDATA <= rdata_d;
      end else begin
         RDATA <= 16'h0000;
      end
   end

endmodule // anps_partner_status

/* File: tb/anps_link_partner.sv */
// Link partner model feeding received codewords
`timescale 1ns/1ps
module anps_link_partner (
   input  wire         clk,
   output logic        valid = 1'b0,
   output logic [15:0] data = 16'h0000
);
   task automatic send(input logic [15:0] w);
      @(posedge clk);
      valid <= 1'b1;
      data <= w;
      @(posedge clk);
      valid <= 1'b0;
      // Stale word never held
      data <= ~w;
   endtask
endmodule // anps_link_partner

/* File: tb/anps_partner_status_properties.sv */
// Port checker of the partner status bank
`timescale 1ns/1ps
module anps_partner_status_properties #(
   parameter MATCH_COUNT = 3
) (
   input wire        SYS_CLK,
   input wire        RESET,
   input wire [4:0]  ADDR,
   input wire        RD,
   input wire [15:0] RDATA,
   input wire        CW_VALID,
   input wire        LP_AN_ABLE,
   input wire        PD_FAULT,
   input wire        NEG_RESTART,
   input wire        SPEED_CONFIG_PIN,
   input wire [15:0] ADVERT
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   wire rd_x = RD && ADDR == 5'h06;
   wire calm = !PD_FAULT && !CW_VALID && !NEG_RESTART;
   AST_RDATA_IDLE: assert property (!RD |=> RDATA == 16'h0000)
      else $error("read data not idle");
   AST_EXP_RSVD: assert property (rd_x |=> !RDATA[2] && RDATA[15:5] == 0)
      else $error("reserved bits set");
   AST_LP_RSVD: assert property (RD && ADDR == 5'h05 |=> RDATA[12:11] == 0)
      else $error("partner reserved bits set");
   AST_ADV_NP: assert property (ADVERT[15:14] == 2'h0)
      else $error("local next page set");
   AST_PDF_LATCH: assert property (PD_FAULT ##1 !rd_x ##1 rd_x |=> RDATA[4])
      else $error("fault flag lost");
   AST_READ_CLEAR: assert property (rd_x && calm ##1 calm ##1 rd_x && calm
      |=> !RDATA[4] && !RDATA[1]) else $error("sticky bit kept");
   AST_LP_AN: assert property (LP_AN_ABLE && !NEG_RESTART ##1 rd_x
      && !NEG_RESTART |=> RDATA[0]) else $error("able bit lost");
   AST_STRAP: assert property ($fell(RESET)
      |=> ADVERT[5] == $past(SPEED_CONFIG_PIN)) else $error("strap lost");
   cover property (rd_x ##1 RDATA[1]);
   cover property (PD_FAULT ##2 rd_x);
   cover property ($fell(RESET) ##1 ADVERT[5]);
endmodule // anps_partner_status_properties

/* File: tb/tb_autoneg_partner_status.sv */
// Self-checking testbench of the partner status bank
`timescale 1ns/1ps
`include "anps_defines.vh"
module tb_autoneg_partner_status;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_p = 1'b0;
   logic        lp_an = 1'b0, pdf = 1'b0, rstrt = 1'b0, pin = 1'b1, cw_v, irq;
   logic [4:0]  addr = 5'h00;
   logic [15:0] wdata = 16'h0000, w = 16'h0049, v, rdata, advert, cw_d;
   logic [15:0] expq[$];
   int          error_cnt = 0, compares = 0;
   anps_partner_status anps_partner_status_i (.SYS_CLK(clk), .RESET(rst),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .CW_VALID(cw_v), .CW_DATA(cw_d), .LP_AN_ABLE(lp_an), .PD_FAULT(pdf),
      .NEG_RESTART(rstrt), .SPEED_CONFIG_PIN(pin), .ADVERT(advert),
      .IRQ(irq));
   anps_link_partner anps_link_partner_i (.clk(clk), .valid(cw_v),
      .data(cw_d));
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Reads note their expected word
   // Random words from a shift register seeded with 73
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic bus(input logic r, input logic [4:0] a,
                      input logic [15:0] d);
      if (r)
         expq.push_back(d);
      @(posedge clk);
      rd <= r;
      wr <= !r;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) rd_p <= rd;
   always @(negedge clk) if (rd_p) chk(rdata, expq.pop_front());
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 chk(advert, 16'h01A1);
      bus(1, 5'h06, 16'h0000);
      bus(1, 5'h05, 16'h0000);
      bus(1, 5'h1F, 16'h0000);
      bus(0, 5'h19, 16'h0003);
      $display("Reset test done");
      w = lfsr(w);
      v = ~w;
      for (int i = 0; i < 4; i++)
         anps_link_partner_i.send(i < 2 ? w : v);
      bus(1, 5'h06, 16'h0000);
      anps_link_partner_i.send(v);
      bus(0, 5'h05, w);
      bus(1, 5'h05, v & 16'hE7FF);
      bus(1, 5'h06, {12'h000, v[15], 3'h2});
      bus(1, 5'h06, {12'h000, v[15], 3'h0});
      chk({15'h0000, irq}, 16'h0001);
      bus(0, 5'h18, 16'h0002);
      #1 chk({15'h0000, irq}, 16'h0000);
      $display("Page test done");
      bus(0, 5'h19, 16'h0002);
      pdf <= 1'b1;
      lp_an <= 1'b1;
      @(posedge clk);
      pdf <= 1'b0;
      bus(1, 5'h06, {12'h001, v[15], 3'h1});
      bus(1, 5'h06, {12'h000, v[15], 3'h1});
      chk({15'h0000, irq}, 16'h0000);
      bus(0, 5'h19, 16'h0003);
      #1 chk({15'h0000, irq}, 16'h0001);
      bus(0, 5'h18, 16'h0001);
      #1 chk({15'h0000, irq}, 16'h0000);
      rstrt <= 1'b1;
      lp_an <= 1'b0;
      @(posedge clk);
      rstrt <= 1'b0;
      bus(1, 5'h05, 16'h0000);
      bus(1, 5'h06, 16'h0000);
      bus(0, 5'h04, 16'hFFFF);
      #1 chk(advert, 16'h3FFF);
      $display("Fault and restart test done");
      end_of_test;
   end
endmodule // tb_autoneg_partner_status
bind anps_partner_status anps_partner_status_properties #(
   .MATCH_COUNT(MATCH_COUNT)) anps_props_i (.SYS_CLK(SYS_CLK),
   .RESET(RESET), .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .CW_VALID(CW_VALID),
   .LP_AN_ABLE(LP_AN_ABLE), .PD_FAULT(PD_FAULT), .NEG_RESTART(NEG_RESTART),
   .SPEED_CONFIG_PIN(SPEED_CONFIG_PIN), .ADVERT(ADVERT));
